// [test/test_pwmsc_top.sv]
// Purpose: Self-checking bench of the PWM slice control block.
// Assumes: Period of 8 PWM clocks in every waveform case.
// Notes: Waveforms are judged by counts over whole periods.
`default_nettype none
module test_pwmsc_top;
	import pwmsc_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {
		logic [11:0] a;
		logic w;
		logic [7:0] d;
		logic [7:0] e;
	} pwmsc_reg_row_t;
	typedef struct {
		logic [7:0] cfg, pre, p1, p2;
		int eh1, er1, eh2, er2, efw;
		logic [7:0] eflg;
	} pwmsc_wave_row_t;
	logic clk, reset, wr, rd_stb, ext_reset, out_one, out_two, irq;
	logic [11:0] addr;
	logic [7:0] wdata, rdata, got;
	int bad_count, samples_checked, cycles, h1, r1, h2, r2, fw;
	pwmsc_reg_row_t regs [15] = '{
		'{ADDR_FLAGS, 0, 8'h00, 8'h00}, '{ADDR_ENABLES, 0, 8'h00, 8'h00},
		'{ADDR_CONTROL, 0, 8'h00, 8'h00}, '{ADDR_CONFIG, 0, 8'h00, 8'h00},
		'{ADDR_P1_LO, 0, 8'h00, 8'h00}, '{ADDR_P1_HI, 0, 8'h00, 8'h00},
		'{ADDR_ENABLES, 1, 8'hFF, 8'h03}, '{ADDR_CONFIG, 1, 8'hFF, 8'hCF},
		'{ADDR_CONFIG, 1, 8'h00, 8'h00}, '{ADDR_P1_LO, 1, 8'h34, 8'h34},
		'{ADDR_P1_HI, 1, 8'h12, 8'h12}, '{ADDR_CONTROL, 1, 8'h03, 8'h03},
		'{ADDR_CONTROL, 1, 8'h00, 8'h00}, '{12'h49B, 1, 8'hFF, 8'h00},
		'{ADDR_FLAGS, 1, 8'hFF, 8'h00}};
	pwmsc_wave_row_t waves [11] = '{
		'{8'h00, 8'h00, 8'h03, 8'h05, 24, 8, 40, 8, 8, 8'h03},
		'{8'h01, 8'h00, 8'h03, 8'h05, 24, 8, 40, 8, 0, 8'h03},
		'{8'h02, 8'h00, 8'h02, 8'h01, 32, 8, 16, 8, 0, 8'h03},
		'{8'h03, 8'h00, 8'h02, 8'h06, 32, 8, 32, 8, 0, 8'h03},
		'{8'h04, 8'h00, 8'h03, 8'h00, 64, 0, 64, 0, 0, 8'h03},
		'{8'h05, 8'h00, 8'h03, 8'h05, 32, 4, 32, 4, 4, 8'h03},
		'{8'h06, 8'h00, 8'h03, 8'h05, 0, 0, 0, 0, 0, 8'h00},
		'{8'h07, 8'h00, 8'h03, 8'h05, 0, 0, 0, 0, 0, 8'h00},
		'{8'h00, 8'h01, 8'h03, 8'h05, 24, 4, 40, 4, 4, 8'h03},
		'{8'hC0, 8'h00, 8'h03, 8'h05, 40, 8, 24, 8, 0, 8'h03},
		'{8'h08, 8'h00, 8'h03, 8'h05, 12, 4, 20, 4, 0, 8'h03}};

	pwmsc_top DUT (
		.I_CLK(clk), .I_RESET(reset), .I_ADDR(addr), .I_WDATA(wdata),
		.I_WR(wr), .I_RD(rd_stb), .O_RDATA(rdata),
		.I_EXT_RESET(ext_reset), .O_SLICE_OUT_ONE(out_one),
		.O_SLICE_OUT_TWO(out_two), .O_IRQ(irq)
	);

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Cuts a hang short; the tests need well under this many cycles.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 30000) begin
			bad_count++;
			$display("CHECK FAILED at %0t: timeout", $time);
			wrap_up();
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen,
				exp);
		end
	endtask

	task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [11:0] a);
		@(posedge clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clk);
		rd_stb <= 1'b0;
		@(negedge clk);
		got = rdata;
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Counts high samples, rises and out-one falls seen with out-two high.
	task automatic measure(input int n);
		logic a, b;
		@(negedge clk);
		a = out_one;
		b = out_two;
		h1 = 0;
		r1 = 0;
		h2 = 0;
		r2 = 0;
		fw = 0;
		repeat (n) begin
			@(negedge clk);
			if (out_one === 1'b1) h1++;
			if (out_one === 1'b1 && a !== 1'b1) r1++;
			if (out_two === 1'b1) h2++;
			if (out_two === 1'b1 && b !== 1'b1) r2++;
			if (out_one !== 1'b1 && a === 1'b1 && out_two === 1'b1) fw++;
			a = out_one;
			b = out_two;
		end
	endtask

	task automatic setup(input logic [7:0] cfg, input logic [7:0] pre,
		input logic [7:0] p1, input logic [7:0] p2, input logic [7:0] con);
		wr_reg(ADDR_CONTROL, 8'h00);
		wr_reg(ADDR_FLAGS, 8'h00);
		wr_reg(ADDR_CONFIG, cfg);
		wr_reg(ADDR_PRESCALE, pre);
		wr_reg(ADDR_PERIOD_LO, 8'h08);
		wr_reg(ADDR_PERIOD_HI, 8'h00);
		wr_reg(ADDR_P1_LO, p1);
		wr_reg(ADDR_P1_HI, 8'h00);
		wr_reg(ADDR_P2_LO, p2);
		wr_reg(ADDR_P2_HI, 8'h00);
		wr_reg(ADDR_CONTROL, con);
		idle(40);
	endtask

	// Waits for a pulse on output one, then raises the external reset.
	task automatic ext_hit(input logic lvl);
		logic a;
		int n;
		a = 1'b1;
		n = 0;
		while (!(out_one === 1'b1 && a === 1'b0) && n < 40) begin
			a = out_one;
			@(negedge clk);
			n++;
		end
		@(posedge clk);
		ext_reset <= lvl;
		idle(4);
		measure(2);
	endtask

	initial begin
		reset = 1'b1;
		addr = '0;
		wdata = 8'h00;
		wr = 1'b0;
		rd_stb = 1'b0;
		ext_reset = 1'b0;
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		foreach (regs[i]) begin
			if (regs[i].w) wr_reg(regs[i].a, regs[i].d);
			rd_reg(regs[i].a);
			check(16'(got), 16'(regs[i].e));
		end
		$display("test register map done");
		foreach (waves[i]) begin
			setup(waves[i].cfg, waves[i].pre, waves[i].p1, waves[i].p2, 8'h80);
			measure(64);
			check(16'(h1), 16'(waves[i].eh1));
			check(16'(r1), 16'(waves[i].er1));
			check(16'(h2), 16'(waves[i].eh2));
			check(16'(r2), 16'(waves[i].er2));
			check(16'(fw), 16'(waves[i].efw));
			rd_reg(ADDR_FLAGS);
			check(16'(got), 16'(waves[i].eflg));
		end
		$display("test waveform modes done");
		wr_reg(ADDR_CONTROL, 8'h00);
		wr_reg(ADDR_CONFIG, 8'hC0);
		idle(3);
		check(16'({out_one, out_two}), 16'h0003);
		wr_reg(ADDR_ENABLES, 8'h01);
		setup(8'h00, 8'h00, 8'h03, 8'h05, 8'h80);
		check(16'(irq), 16'h0001);
		wr_reg(ADDR_CONTROL, 8'h00);
		wr_reg(ADDR_FLAGS, 8'h00);
		wr_reg(ADDR_FLAGS, 8'hFF);
		rd_reg(ADDR_FLAGS);
		check(16'(got), 16'h0000);
		setup(8'h00, 8'h00, 8'h03, 8'h05, 8'h80);
		wr_reg(ADDR_CONTROL, 8'h00);
		wr_reg(ADDR_FLAGS, 8'h02);
		rd_reg(ADDR_FLAGS);
		check(16'(got), 16'h0002);
		idle(3);
		check(16'(irq), 16'h0000);
		wr_reg(ADDR_ENABLES, 8'h02);
		idle(3);
		check(16'(irq), 16'h0001);
		wr_reg(ADDR_FLAGS, 8'h00);
		idle(3);
		check(16'(irq), 16'h0000);
		$display("test interrupt flags done");
		setup(8'h00, 8'h00, 8'h03, 8'h05, 8'h80);
		wr_reg(ADDR_P1_LO, 8'h06);
		measure(64);
		check(16'(h1), 16'd24);
		wr_reg(ADDR_CONTROL, 8'h84);
		idle(20);
		rd_reg(ADDR_CONTROL);
		check(16'(got), 16'h0080);
		measure(64);
		check(16'(h1), 16'd48);
		$display("test reload done");
		setup(8'h00, 8'h00, 8'h07, 8'h05, 8'h81);
		ext_hit(1'b1);
		check(16'(h1), 16'd0);
		idle(16);
		ext_reset <= 1'b0;
		idle(20);
		measure(64);
		check(16'(h1), 16'd56);
		wr_reg(ADDR_CONTROL, 8'h83);
		idle(20);
		measure(16);
		check(16'(h1), 16'd0);
		@(posedge clk);
		ext_reset <= 1'b1;
		idle(20);
		measure(64);
		check(16'(h1), 16'd56);
		@(posedge clk);
		ext_reset <= 1'b0;
		wr_reg(ADDR_CONTROL, 8'h80);
		idle(20);
		ext_hit(1'b1);
		check(16'(h1), 16'd1);
		idle(16);
		measure(16);
		check(16'(h1), 16'd0);
		@(posedge clk);
		ext_reset <= 1'b0;
		$display("test external reset done");
		wrap_up();
	end
endmodule
`default_nettype wire

// [verilog/pwmsc_pkg.sv]
// Purpose: Shared constants and types of the PWM slice control block.
// Assumes: Byte-wide registers on a plain address/strobe port.
// Notes: Offsets are byte addresses on that port.
`default_nettype none
package pwmsc_pkg;
	localparam int ADDR_W = 12;
	localparam logic [11:0] ADDR_PERIOD_LO = 12'h48F;
	localparam logic [11:0] ADDR_PERIOD_HI = 12'h490;
	localparam logic [11:0] ADDR_PRESCALE = 12'h491;
	localparam logic [11:0] ADDR_FLAGS = 12'h493;
	localparam logic [11:0] ADDR_ENABLES = 12'h494;
	localparam logic [11:0] ADDR_CONTROL = 12'h495;
	localparam logic [11:0] ADDR_CONFIG = 12'h496;
	localparam logic [11:0] ADDR_P1_LO = 12'h497;
	localparam logic [11:0] ADDR_P1_HI = 12'h498;
	localparam logic [11:0] ADDR_P2_LO = 12'h499;
	localparam logic [11:0] ADDR_P2_HI = 12'h49A;
	localparam int CON_ENABLE = 7;
	localparam int CON_RELOAD = 2;
	localparam int CON_ERS_POL = 1;
	localparam int CON_ERS_NOW = 0;
	localparam int CFG_INV_TWO = 7;
	localparam int CFG_INV_ONE = 6;
	localparam int CFG_PUSH_PULL = 3;
	localparam int FLAG_TWO = 1;
	localparam int FLAG_ONE = 0;
	localparam logic [7:0] CFG_MASK = 8'hCF;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [15:0] WORD_RESET = 16'h0000;
	localparam logic [1:0] FLAG_RESET = 2'h0;
	typedef enum logic [2:0] {
		MODE_LEFT = 3'b000,
		MODE_RIGHT = 3'b001,
		MODE_CENTER = 3'b010,
		MODE_VARIABLE = 3'b011,
		MODE_SET = 3'b100,
		MODE_TOGGLE = 3'b101,
		MODE_RSV_A = 3'b110,
		MODE_RSV_B = 3'b111
	} pwmsc_mode_t;
endpackage
`default_nettype wire

// [verilog/pwmsc_slice.sv]
// Purpose: Waveform and interrupt event of one slice output.
// Assumes: Parameters are working copies, stable within a period.
// Notes: The level and event update on the PWM tick; a reserved mode clears the level at once.
`default_nettype none
module pwmsc_slice
	import pwmsc_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_reset,
	input wire pwmsc_mode_t i_mode,
	input wire logic [15:0] i_own,
	input wire logic [15:0] i_p1,
	input wire logic [15:0] i_p2,
	input wire logic [15:0] i_period,
	pwmsc_time_if.snk tb,
	output logic o_level,
	output logic o_event
);
	logic next_level;
	logic next_event;
	wire [16:0] right_start = {1'b0, i_period} - {1'b0, i_own};
	wire own_hit = (tb.count == i_own);
	wire left_lvl = (tb.count < i_own);
	wire right_lvl = ({1'b0, tb.count} >= right_start);
	wire mode_reserved = (i_mode[2:1] == 2'b11);
	always_comb begin
		next_level = 1'b0;
		next_event = 1'b0;
		case (i_mode)
			MODE_LEFT: begin
				next_level = left_lvl;
				next_event = o_level & ~next_level;
			end
			MODE_RIGHT: begin
				next_level = right_lvl;
				next_event = ~o_level & next_level;
			end
			MODE_CENTER: begin
				next_level = left_lvl | right_lvl;
				next_event = o_level ^ next_level;
			end
			MODE_VARIABLE: begin
				next_level = (tb.count == i_p1) ? 1'b1 :
					(tb.count == i_p2) ? 1'b0 : o_level;
				next_event = own_hit;
			end
			MODE_SET: begin
				next_level = own_hit | o_level;
				next_event = own_hit;
			end
			MODE_TOGGLE: begin
				next_level = own_hit ^ o_level;
				next_event = own_hit;
			end
			default: begin
				next_level = 1'b0;
				next_event = 1'b0;
			end
		endcase
	end
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			o_level <= 1'b0;
			o_event <= 1'b0;
		end else if (!tb.run) begin
			o_level <= 1'b0;
			o_event <= 1'b0;
		end else begin
			o_level <= (tb.tick || mode_reserved) ? next_level : o_level;
			o_event <= tb.tick & next_event;
		end
	end
	a_reserved_idle: assert property (@(posedge i_clk) disable iff (i_reset)
		(i_mode[2:1] == 2'b11) ##1 (i_mode[2:1] == 2'b11) |-> !o_level)
		else $error("Reserved mode left an output active.");
	a_left_level: assert property (@(posedge i_clk) disable iff (i_reset)
		(tb.run && tb.tick && i_mode == MODE_LEFT) |=>
		(o_level == $past(left_lvl)))
		else $error("Left aligned level is wrong.");
endmodule
`default_nettype wire

// [verilog/pwmsc_time_if.sv]
// Purpose: Carries the time base from the timer to the slices.
// Assumes: Single clock domain.
// Notes: The tick is one cycle of the prescaled PWM clock.
`default_nettype none
interface pwmsc_time_if;
	logic run;
	logic tick;
	logic period_evt;
	logic [15:0] count;
	modport src (input run, output tick, output period_evt, output count);
	modport snk (input run, input tick, input period_evt, input count);
endinterface
`default_nettype wire

// [verilog/pwmsc_timebase.sv]
// Purpose: Prescaler and period counter of the PWM.
// Assumes: Clock enable comes from the run signal of the interface.
// Notes: Both counters clear while run is low.
`default_nettype none
module pwmsc_timebase
	import pwmsc_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic [7:0] i_prescale,
	input wire logic [15:0] i_period,
	pwmsc_time_if.src tb
);
	logic [7:0] pre_cnt;
	logic [15:0] count;
	wire pre_hit = (pre_cnt == i_prescale);
	wire [15:0] last = (i_period == WORD_RESET) ? WORD_RESET :
		i_period - 16'h0001;
	assign tb.tick = tb.run & pre_hit;
	assign tb.period_evt = tb.tick & (count == last);
	assign tb.count = count;
	// Divide by prescale plus one, count period clocks.
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			pre_cnt <= BYTE_RESET;
			count <= WORD_RESET;
		end else if (!tb.run) begin
			pre_cnt <= BYTE_RESET;
			count <= WORD_RESET;
		end else begin
			pre_cnt <= pre_hit ? BYTE_RESET : pre_cnt + 8'h01;
			if (tb.tick) begin
				count <= tb.period_evt ? WORD_RESET : count + 16'h0001;
			end
		end
	end
	a_prescale_div: assert property (@(posedge i_clk) disable iff (i_reset)
		(tb.tick && tb.run) |=> !tb.run || (pre_cnt == 8'h00))
		else $error("Prescaler did not restart after tick.");
endmodule
`default_nettype wire

// [verilog/pwmsc_top.sv]
// Purpose: Control, interrupt and slice configuration of one PWM channel.
// Assumes: Byte register port, read data one cycle after the read strobe.
// Notes: Unmapped reads return zero; unmapped writes are ignored.
`default_nettype none
module pwmsc_top
	import pwmsc_pkg::*;
(
	input wire logic I_CLK,
	input wire logic I_RESET,
	input wire logic [pwmsc_pkg::ADDR_W-1:0] I_ADDR,
	input wire logic [7:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	output logic [7:0] O_RDATA,
	input wire logic I_EXT_RESET,
	output logic O_SLICE_OUT_ONE,
	output logic O_SLICE_OUT_TWO,
	output logic O_IRQ
);
	import pwmsc_pkg::*;

	logic [15:0] period_value;
	logic [7:0] clock_prescale;
	logic [1:0] flags;
	logic [1:0] irq_enables;
	logic module_enable;
	logic reload_request;
	logic ext_reset_polarity;
	logic ext_reset_immediate;
	logic [7:0] config_reg;
	logic [15:0] param_one_value;
	logic [15:0] param_two_value;
	logic [15:0] period_work;
	logic [15:0] param_one_work;
	logic [15:0] param_two_work;
	logic halted;
	logic stop_pending;
	logic phase;
	logic [1:0] slice_level;
	logic [1:0] slice_event;
	logic [15:0] own_param [2];

	pwmsc_time_if tb_bus ();

	wire wr_period_lo = I_WR && (I_ADDR == ADDR_PERIOD_LO);
	wire wr_period_hi = I_WR && (I_ADDR == ADDR_PERIOD_HI);
	wire wr_prescale = I_WR && (I_ADDR == ADDR_PRESCALE);
	wire wr_flags = I_WR && (I_ADDR == ADDR_FLAGS);
	wire wr_enables = I_WR && (I_ADDR == ADDR_ENABLES);
	wire wr_control = I_WR && (I_ADDR == ADDR_CONTROL);
	wire wr_config = I_WR && (I_ADDR == ADDR_CONFIG);
	wire wr_p1_lo = I_WR && (I_ADDR == ADDR_P1_LO);
	wire wr_p1_hi = I_WR && (I_ADDR == ADDR_P1_HI);
	wire wr_p2_lo = I_WR && (I_ADDR == ADDR_P2_LO);
	wire wr_p2_hi = I_WR && (I_ADDR == ADDR_P2_HI);

	wire [7:0] control_byte = {module_enable, 4'h0, reload_request,
		ext_reset_polarity, ext_reset_immediate};
	wire [7:0] read_mux =
		(I_ADDR == ADDR_PERIOD_LO) ? period_value[7:0] :
		(I_ADDR == ADDR_PERIOD_HI) ? period_value[15:8] :
		(I_ADDR == ADDR_PRESCALE) ? clock_prescale :
		(I_ADDR == ADDR_FLAGS) ? {6'h00, flags} :
		(I_ADDR == ADDR_ENABLES) ? {6'h00, irq_enables} :
		(I_ADDR == ADDR_CONTROL) ? control_byte :
		(I_ADDR == ADDR_CONFIG) ? config_reg :
		(I_ADDR == ADDR_P1_LO) ? param_one_value[7:0] :
		(I_ADDR == ADDR_P1_HI) ? param_one_value[15:8] :
		(I_ADDR == ADDR_P2_LO) ? param_two_value[7:0] :
		(I_ADDR == ADDR_P2_HI) ? param_two_value[15:8] : BYTE_RESET;

	wire pwmsc_mode_t mode = pwmsc_mode_t'(config_reg[2:0]);
	wire push_pull = config_reg[CFG_PUSH_PULL];
	wire ext_active = I_EXT_RESET ^ ext_reset_polarity;
	wire load_now = tb_bus.period_evt && reload_request;
	wire sync_copy = !tb_bus.run || load_now;
	wire [1:0] next_flags = slice_event |
		(wr_flags ? (flags & I_WDATA[1:0]) : flags);
	wire next_reload = wr_control ? I_WDATA[CON_RELOAD] :
		(load_now ? 1'b0 : reload_request);
	wire next_out_one = (slice_level[0] & ~(push_pull & phase)) ^
		config_reg[CFG_INV_ONE];
	wire next_out_two = (slice_level[1] & ~(push_pull & ~phase)) ^
		config_reg[CFG_INV_TWO];

	assign tb_bus.run = module_enable && !halted;
	assign own_param[0] = param_one_work;
	assign own_param[1] = param_two_work;

	pwmsc_timebase u_timebase (
		.i_clk(I_CLK),
		.i_reset(I_RESET),
		.i_prescale(clock_prescale),
		.i_period(period_work),
		.tb(tb_bus.src)
	);

	for (genvar g = 0; g < 2; g++) begin : g_slice
		pwmsc_slice u_slice (
			.i_clk(I_CLK),
			.i_reset(I_RESET),
			.i_mode(mode),
			.i_own(own_param[g]),
			.i_p1(param_one_work),
			.i_p2(param_two_work),
			.i_period(period_work),
			.tb(tb_bus.snk),
			.o_level(slice_level[g]),
			.o_event(slice_event[g])
		);
	end

	always_ff @(posedge I_CLK or posedge I_RESET) begin
		if (I_RESET) begin
			period_value <= WORD_RESET;
			clock_prescale <= BYTE_RESET;
			param_one_value <= WORD_RESET;
			param_two_value <= WORD_RESET;
			config_reg <= BYTE_RESET;
			irq_enables <= FLAG_RESET;
		end else begin
			if (wr_period_lo) period_value[7:0] <= I_WDATA;
			if (wr_period_hi) period_value[15:8] <= I_WDATA;
			if (wr_prescale) clock_prescale <= I_WDATA;
			if (wr_p1_lo) param_one_value[7:0] <= I_WDATA;
			if (wr_p1_hi) param_one_value[15:8] <= I_WDATA;
			if (wr_p2_lo) param_two_value[7:0] <= I_WDATA;
			if (wr_p2_hi) param_two_value[15:8] <= I_WDATA;
			if (wr_config) config_reg <= I_WDATA & CFG_MASK;
			if (wr_enables) irq_enables <= I_WDATA[1:0];
		end
	end

	always_ff @(posedge I_CLK or posedge I_RESET) begin
		if (I_RESET) begin
			module_enable <= 1'b0;
			reload_request <= 1'b0;
			ext_reset_polarity <= 1'b0;
			ext_reset_immediate <= 1'b0;
			flags <= FLAG_RESET;
			O_RDATA <= BYTE_RESET;
			O_IRQ <= 1'b0;
		end else begin
			if (wr_control) begin
				module_enable <= I_WDATA[CON_ENABLE];
				ext_reset_polarity <= I_WDATA[CON_ERS_POL];
				ext_reset_immediate <= I_WDATA[CON_ERS_NOW];
			end
			reload_request <= next_reload;
			flags <= next_flags;
			O_RDATA <= I_RD ? read_mux : BYTE_RESET;
			O_IRQ <= |(flags & irq_enables);
		end
	end

	always_ff @(posedge I_CLK or posedge I_RESET) begin
		if (I_RESET) begin
			period_work <= WORD_RESET;
			param_one_work <= WORD_RESET;
			param_two_work <= WORD_RESET;
		end else if (sync_copy) begin
			period_work <= period_value;
			param_one_work <= param_one_value;
			param_two_work <= param_two_value;
		end
	end

	always_ff @(posedge I_CLK or posedge I_RESET) begin
		if (I_RESET) begin
			halted <= 1'b0;
			stop_pending <= 1'b0;
		end else if (!module_enable) begin
			halted <= 1'b0;
			stop_pending <= 1'b0;
		end else if (ext_active && ext_reset_immediate && tb_bus.tick) begin
			halted <= 1'b1;
		end else if (stop_pending && tb_bus.period_evt) begin
			halted <= 1'b1;
			stop_pending <= 1'b0;
		end else if (ext_active && !ext_reset_immediate && !halted) begin
			stop_pending <= 1'b1;
		end else if (!ext_active && halted) begin
			halted <= 1'b0;
		end
	end

	always_ff @(posedge I_CLK or posedge I_RESET) begin
		if (I_RESET) begin
			phase <= 1'b0;
			O_SLICE_OUT_ONE <= 1'b0;
			O_SLICE_OUT_TWO <= 1'b0;
		end else begin
			if (!tb_bus.run) phase <= 1'b0;
			else if (tb_bus.period_evt) phase <= ~phase;
			O_SLICE_OUT_ONE <= next_out_one;
			O_SLICE_OUT_TWO <= next_out_two;
		end
	end

	a_flag_clear: assert property (@(posedge I_CLK) disable iff (I_RESET)
		(wr_flags && I_WDATA[1:0] == 2'b00 && slice_event == 2'b00)
		|=> (flags == 2'b00))
		else $error("Writing zero did not clear the flags.");
	a_flag_set_wins: assert property (@(posedge I_CLK) disable iff (I_RESET)
		(slice_event[0] && wr_flags) |=> flags[FLAG_ONE])
		else $error("Flag event lost against a clear.");
	a_reload_clear: assert property (@(posedge I_CLK) disable iff (I_RESET)
		(load_now && !wr_control) |=> !reload_request)
		else $error("Reload bit not cleared after the copy.");
	a_reload_copy: assert property (@(posedge I_CLK) disable iff (I_RESET)
		load_now |=> (param_one_work == $past(param_one_value)) &&
		(period_work == $past(period_value)))
		else $error("Working copies not loaded at period event.");
	a_disable_out: assert property (@(posedge I_CLK) disable iff (I_RESET)
		(!module_enable ##1 !module_enable) |=>
		(O_SLICE_OUT_ONE == $past(config_reg[CFG_INV_ONE])))
		else $error("Disabled output is not at its default.");
	a_irq_request: assert property (@(posedge I_CLK) disable iff (I_RESET)
		((flags & irq_enables) != 2'b00) |=> O_IRQ)
		else $error("Interrupt request missing for enabled flag.");
	a_irq_masked: assert property (@(posedge I_CLK) disable iff (I_RESET)
		(irq_enables == 2'b00) |=> !O_IRQ)
		else $error("Interrupt raised while both enables clear.");
	a_stop_now: assert property (@(posedge I_CLK) disable iff (I_RESET)
		(module_enable && !wr_control && ext_active &&
		ext_reset_immediate && tb_bus.tick) |=> !tb_bus.run)
		else $error("Immediate external reset did not stop.");
	a_stop_end: assert property (@(posedge I_CLK) disable iff (I_RESET)
		(module_enable && !wr_control && stop_pending && tb_bus.period_evt)
		|=> halted)
		else $error("Deferred external reset did not stop.");
	a_read_flags: assert property (@(posedge I_CLK) disable iff (I_RESET)
		(I_RD && I_ADDR == ADDR_FLAGS) |=>
		(O_RDATA == {6'h00, $past(flags)}))
		else $error("Flag read returned a wrong value.");
	c_reload: cover property (@(posedge I_CLK) disable iff (I_RESET)
		load_now);
	c_irq: cover property (@(posedge I_CLK) disable iff (I_RESET)
		O_IRQ);
	c_halt: cover property (@(posedge I_CLK) disable iff (I_RESET)
		module_enable && halted);
	c_push_pull: cover property (@(posedge I_CLK) disable iff (I_RESET)
		push_pull && tb_bus.period_evt && phase);
endmodule
`default_nettype wire
